//--- srq_cond_pkg.sv
// Purpose: Shared constants and types of the service-request condition block
// Assumes: One 100 MHz clock; loop messages arrive already framed and decoded
// Notes:   Register counts, widths and default values live here only
package srq_cond_pkg;

  localparam int CTRL_COUNT = 14;
  localparam int CHAR_COUNT = 12;
  localparam int CTRL_W     = 4;
  localparam int CHAR_W     = 8;
  localparam int COND_COUNT = 11;

  typedef logic [CTRL_W-1:0] ctrl_val_t;
  typedef logic [CHAR_W-1:0] char_val_t;
  typedef logic [3:0]        reg_index_t;

  localparam reg_index_t IDX_PRIMARY = 4'h0;
  localparam reg_index_t IDX_BUFFERS = 4'h1;
  localparam reg_index_t IDX_EVENTS  = 4'h2;
  localparam reg_index_t IDX_LAST    = 4'hd;
  localparam reg_index_t CHAR_LAST   = 4'hb;

  localparam int BIT_MASTER     = 3;
  localparam int BIT_RX_ERROR   = 2;
  localparam int BIT_RX_LOST    = 0;
  localparam int BIT_RX_FULL    = 3;
  localparam int BIT_RX_NEMPTY  = 2;
  localparam int BIT_TX_NFULL   = 1;
  localparam int BIT_TX_EMPTY   = 0;
  localparam int BIT_MANUAL_KEY = 2;
  localparam int BIT_AUTODISC   = 1;
  localparam int BIT_BREAK      = 0;

  localparam ctrl_val_t PRIMARY_RST      = 4'h0;
  localparam ctrl_val_t BUFFERS_RST      = 4'h0;
  localparam ctrl_val_t EVENTS_RST       = 4'h0;
  localparam ctrl_val_t PRIMARY_RST_OPEN = 4'hd;
  localparam ctrl_val_t BUFFERS_RST_OPEN = 4'h5;
  localparam ctrl_val_t EVENTS_RST_OPEN  = 4'h2;

  // Defaults of the remaining control registers, index 13 first
  localparam logic [CTRL_COUNT-1:0][CTRL_W-1:0] CTRL_RST =
    {4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'he, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0};
  localparam char_val_t CHAR_RST = 8'h00;

  typedef enum logic [2:0] {
    MSG_DDL0, MSG_DDL2, MSG_DATA, MSG_SET_EN, MSG_CLR_EN, MSG_REMOTE_WR
  } msg_kind_t;

  typedef struct packed {
    logic      valid;
    msg_kind_t kind;
    char_val_t data;
  } loop_msg_t;

  typedef struct packed {
    logic rx_parity_err;
    logic rx_frame_err;
    logic rx_overrun;
    logic rx_overflow;
    logic rx_lost;
    logic rx_full;
    logic rx_not_empty;
    logic tx_not_full;
    logic tx_empty;
    logic manual_request_key;
    logic autodisconnect;
    logic break_received;
  } cond_t;

  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_CHAR} sel_t;

  typedef enum logic [2:0] {
    WR_NONE, WR_SELECT_CTRL, WR_SELECT_CHAR, WR_CTRL, WR_CHAR, WR_BIT_SET, WR_BIT_CLR
  } wr_op_t;

  typedef struct packed {
    wr_op_t     op;
    reg_index_t index;
    logic [1:0] bit_sel;
    char_val_t  data;
    logic       advance;
  } wr_cmd_t;

  typedef struct packed {
    logic [CTRL_COUNT-1:0][CTRL_W-1:0] ctrl;
    logic [CHAR_COUNT-1:0][CHAR_W-1:0] chars;
    sel_t                              sel;
    reg_index_t                        sel_idx;
    logic                              init_pend;
    logic                              srq;
    logic [COND_COUNT-1:0]             armed;
    ctrl_val_t                         rd_ctrl;
    char_val_t                         rd_char;
  } state_t;

endpackage

//--- srq_msg_decode.sv
// Purpose: Turns loop listener messages and remote instructions into writes
// Assumes: Caller holds the listener selection state
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
module srq_msg_decode
  import srq_cond_pkg::*;
(
  input  wire srq_cond_pkg::loop_msg_t  msg_in,
  input  wire srq_cond_pkg::sel_t       sel_in,
  input  wire srq_cond_pkg::reg_index_t sel_idx_in,
  output srq_cond_pkg::wr_cmd_t         wr_out
);

  // Enable index 0..11 picks register index[3:2], bit index[1:0]
  function automatic reg_index_t enable_reg(input char_val_t d);
    enable_reg = {2'b00, d[3:2]};
  endfunction

  always_comb
  begin
    wr_out = '0;
    wr_out.op = WR_NONE;
    if (msg_in.valid)
    begin
      case (msg_in.kind)
        MSG_DDL0:
        begin
          wr_out.op = WR_SELECT_CTRL;
          wr_out.index = msg_in.data[3:0];
        end
        MSG_DDL2:
        begin
          wr_out.op = WR_SELECT_CHAR;
          wr_out.index = msg_in.data[3:0];
        end
        MSG_DATA:
        begin
          wr_out.index = sel_idx_in;
          wr_out.data = msg_in.data;
          wr_out.advance = 1'b1;
          if (sel_in == SEL_CTRL)
            wr_out.op = WR_CTRL;
          else if (sel_in == SEL_CHAR)
            wr_out.op = WR_CHAR;
        end
        MSG_SET_EN:
        begin
          wr_out.op = WR_BIT_SET;
          wr_out.index = enable_reg(msg_in.data);
          wr_out.bit_sel = msg_in.data[1:0];
        end
        MSG_CLR_EN:
        begin
          wr_out.op = WR_BIT_CLR;
          wr_out.index = enable_reg(msg_in.data);
          wr_out.bit_sel = msg_in.data[1:0];
        end
        MSG_REMOTE_WR:
        begin
          wr_out.op = WR_CTRL;
          wr_out.index = msg_in.data[7:4];
          wr_out.data = {4'h0, msg_in.data[3:0]};
        end
        default:
          wr_out.op = WR_NONE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- srq_eval.sv
// Purpose: Combines enable bits with live conditions into a pending request
// Assumes: Condition inputs are levels synchronous to the clock
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module srq_eval
  import srq_cond_pkg::*;
(
  input  wire srq_cond_pkg::ctrl_val_t primary_in,
  input  wire srq_cond_pkg::ctrl_val_t buffers_in,
  input  wire srq_cond_pkg::ctrl_val_t events_in,
  input  wire srq_cond_pkg::cond_t     cond_in,
  output logic [COND_COUNT-1:0]         armed_out,
  output logic                          pending_out
);

  logic rx_error;

  always_comb
  begin
    rx_error = cond_in.rx_parity_err | cond_in.rx_frame_err
             | cond_in.rx_overrun | cond_in.rx_overflow;
    armed_out = '0;
    armed_out[0] = primary_in[BIT_RX_ERROR] & rx_error;
    armed_out[1] = primary_in[BIT_RX_LOST] & cond_in.rx_lost;
    armed_out[2] = buffers_in[BIT_RX_FULL] & cond_in.rx_full;
    armed_out[3] = buffers_in[BIT_RX_NEMPTY] & cond_in.rx_not_empty;
    armed_out[4] = buffers_in[BIT_TX_NFULL] & cond_in.tx_not_full;
    armed_out[5] = buffers_in[BIT_TX_EMPTY] & cond_in.tx_empty;
    armed_out[6] = events_in[BIT_MANUAL_KEY] & cond_in.manual_request_key;
    armed_out[7] = events_in[BIT_AUTODISC] & cond_in.autodisconnect;
    armed_out[8] = events_in[BIT_BREAK] & cond_in.break_received;
    armed_out[10:9] = 2'b00;
    pending_out = primary_in[BIT_MASTER] & (|armed_out);
  end

endmodule
`default_nettype wire

//--- srq_cond_top.sv
// Purpose: Control and character register file with service-request conditions
// Assumes: Loop messages are decoded upstream; condition inputs are levels
// Notes:   Defaults reload on reset release and on the front-panel reset key
`timescale 1ns/1ns
`default_nettype none
module srq_cond_top
  import srq_cond_pkg::*;
(
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     reset_key_in,
  input  wire logic                     request_switch_open_in,
  input  wire srq_cond_pkg::loop_msg_t  loop_msg_in,
  input  wire srq_cond_pkg::cond_t      cond_in,
  input  wire srq_cond_pkg::reg_index_t ctrl_rd_index_in,
  input  wire srq_cond_pkg::reg_index_t char_rd_index_in,
  output logic                          service_request_out,
  output logic [COND_COUNT-1:0]         armed_conditions_out,
  output srq_cond_pkg::ctrl_val_t       request_enable_primary_out,
  output srq_cond_pkg::ctrl_val_t       request_enable_buffers_out,
  output srq_cond_pkg::ctrl_val_t       request_enable_events_out,
  output srq_cond_pkg::ctrl_val_t       ctrl_rd_data_out,
  output srq_cond_pkg::char_val_t       char_rd_data_out,
  output logic                          defaults_loading_out
);

  state_t                state_reg;
  state_t                state_next;
  wr_cmd_t               wr_cmd;
  logic [COND_COUNT-1:0] armed;
  logic                  pending;
  logic                  load_defaults;

  // Control register index inside the fourteen
  function automatic logic ctrl_in_range(input reg_index_t idx);
    ctrl_in_range = (idx <= IDX_LAST);
  endfunction

  // Character register index inside the twelve
  function automatic logic char_in_range(input reg_index_t idx);
    char_in_range = (idx <= CHAR_LAST);
  endfunction

  // Default of one control register, switch dependent for the enables
  function automatic ctrl_val_t ctrl_default(input int idx, input logic open_sw);
    ctrl_val_t val;
    val = CTRL_RST[idx];
    if (idx == int'(IDX_PRIMARY))
    begin
      val = open_sw ? PRIMARY_RST_OPEN : PRIMARY_RST;
    end
    else if (idx == int'(IDX_BUFFERS))
    begin
      val = open_sw ? BUFFERS_RST_OPEN : BUFFERS_RST;
    end
    else if (idx == int'(IDX_EVENTS))
    begin
      val = open_sw ? EVENTS_RST_OPEN : EVENTS_RST;
    end
    return val;
  endfunction

  srq_msg_decode u_decode (
    .msg_in     (loop_msg_in),
    .sel_in     (state_reg.sel),
    .sel_idx_in (state_reg.sel_idx),
    .wr_out     (wr_cmd)
  );

  srq_eval u_eval (
    .primary_in  (state_reg.ctrl[IDX_PRIMARY]),
    .buffers_in  (state_reg.ctrl[IDX_BUFFERS]),
    .events_in   (state_reg.ctrl[IDX_EVENTS]),
    .cond_in     (cond_in),
    .armed_out   (armed),
    .pending_out (pending)
  );

  always_comb
  begin
    // reload on power-up or reset key
    load_defaults = state_reg.init_pend | reset_key_in;
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.init_pend = 1'b0;

    if (load_defaults)
    begin
      for (int i = 0; i < CTRL_COUNT; i++)
      begin
        state_next.ctrl[i] = ctrl_default(i, request_switch_open_in);
      end
      for (int j = 0; j < CHAR_COUNT; j++)
      begin
        state_next.chars[j] = CHAR_RST;
      end
      state_next.sel = SEL_NONE;
      state_next.sel_idx = 4'h0;
    end
    else
    begin
      case (wr_cmd.op)
        WR_SELECT_CTRL:
        begin
          state_next.sel = SEL_CTRL;
          state_next.sel_idx = wr_cmd.index;
        end
        WR_SELECT_CHAR:
        begin
          state_next.sel = SEL_CHAR;
          state_next.sel_idx = wr_cmd.index;
        end
        WR_CTRL:
        begin
          // low nibble is the register value
          if (ctrl_in_range(wr_cmd.index))
          begin
            state_next.ctrl[wr_cmd.index] = wr_cmd.data[CTRL_W-1:0];
          end
          if (wr_cmd.advance)
          begin
            if (ctrl_in_range(wr_cmd.index) && wr_cmd.index != IDX_LAST)
            begin
              state_next.sel_idx = wr_cmd.index + 4'h1;
            end
            else
            begin
              state_next.sel = SEL_NONE;
            end
          end
        end
        WR_CHAR:
        begin
          // character registers take the whole byte
          if (char_in_range(wr_cmd.index))
          begin
            state_next.chars[wr_cmd.index] = wr_cmd.data;
          end
          if (char_in_range(wr_cmd.index) && wr_cmd.index != CHAR_LAST)
          begin
            state_next.sel_idx = wr_cmd.index + 4'h1;
          end
          else
          begin
            state_next.sel = SEL_NONE;
          end
        end
        WR_BIT_SET:
        begin
          // remote set of one enable bit
          if (wr_cmd.index <= IDX_EVENTS)
          begin
            state_next.ctrl[wr_cmd.index][wr_cmd.bit_sel] = 1'b1;
          end
        end
        WR_BIT_CLR:
        begin
          // remote clear of one enable bit
          if (wr_cmd.index <= IDX_EVENTS)
          begin
            state_next.ctrl[wr_cmd.index][wr_cmd.bit_sel] = 1'b0;
          end
        end
        default:
        begin
          state_next.sel = state_reg.sel;
        end
      endcase
    end

    state_next.srq = pending & ~load_defaults;
    state_next.armed = load_defaults ? '0 : armed;

    if (ctrl_in_range(ctrl_rd_index_in))
    begin
      state_next.rd_ctrl = state_reg.ctrl[ctrl_rd_index_in];
    end
    else
    begin
      state_next.rd_ctrl = 4'h0;
    end

    if (char_in_range(char_rd_index_in))
    begin
      state_next.rd_char = state_reg.chars[char_rd_index_in];
    end
    else
    begin
      state_next.rd_char = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= '0;
      // defaults load on the first edge
      state_reg.init_pend <= 1'b1;
      state_reg.sel <= SEL_NONE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_comb
  begin
    service_request_out = state_reg.srq;
    armed_conditions_out = state_reg.armed;
    request_enable_primary_out = state_reg.ctrl[IDX_PRIMARY];
    request_enable_buffers_out = state_reg.ctrl[IDX_BUFFERS];
    request_enable_events_out = state_reg.ctrl[IDX_EVENTS];
    ctrl_rd_data_out = state_reg.rd_ctrl;
    char_rd_data_out = state_reg.rd_char;
    defaults_loading_out = state_reg.init_pend;
  end

endmodule
`default_nettype wire

//--- srq_cond_chk.sv
// Purpose: Concurrent checks on the service-request condition block ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to the top module from the bench top file
`timescale 1ns/1ns
`default_nettype none
module srq_cond_chk
  import srq_cond_pkg::*;
(
  input wire logic                    clk_sys_in,
  input wire logic                    rst_b_in,
  input wire logic                    reset_key_in,
  input wire logic                    request_switch_open_in,
  input wire srq_cond_pkg::cond_t     cond_in,
  input wire logic                    service_request_out,
  input wire logic [COND_COUNT-1:0]   armed_conditions_out,
  input wire srq_cond_pkg::ctrl_val_t request_enable_primary_out,
  input wire srq_cond_pkg::ctrl_val_t request_enable_buffers_out,
  input wire srq_cond_pkg::ctrl_val_t request_enable_events_out,
  input wire logic                    defaults_loading_out
);
  logic [COND_COUNT-1:0] ea;
  wire logic        ok = !reset_key_in && !defaults_loading_out;
  wire logic [11:0] en = {request_enable_primary_out, request_enable_buffers_out, request_enable_events_out};
  wire logic [11:0] dv = request_switch_open_in ? {PRIMARY_RST_OPEN, BUFFERS_RST_OPEN, EVENTS_RST_OPEN}
                                                 : {PRIMARY_RST, BUFFERS_RST, EVENTS_RST};

  // Expected armed vector from enables and conditions
  always_comb
  begin
    ea = '0;
    ea[0] = request_enable_primary_out[2] & (cond_in.rx_parity_err | cond_in.rx_frame_err
            | cond_in.rx_overrun | cond_in.rx_overflow);
    ea[1] = request_enable_primary_out[0] & cond_in.rx_lost;
    ea[2] = request_enable_buffers_out[3] & cond_in.rx_full;
    ea[3] = request_enable_buffers_out[2] & cond_in.rx_not_empty;
    ea[4] = request_enable_buffers_out[1] & cond_in.tx_not_full;
    ea[5] = request_enable_buffers_out[0] & cond_in.tx_empty;
    ea[6] = request_enable_events_out[2] & cond_in.manual_request_key;
    ea[7] = request_enable_events_out[1] & cond_in.autodisconnect;
    ea[8] = request_enable_events_out[0] & cond_in.break_received;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  chk_master_gate: assert property (ok && !request_enable_primary_out[3] |=> !service_request_out)
    else $error("request without master gate");
  chk_arm_rx_error: assert property (ok |=> armed_conditions_out[0] == $past(ea[0]))
    else $error("rx error arm wrong");
  chk_arm_rx_lost: assert property (ok |=> armed_conditions_out[1] == $past(ea[1]))
    else $error("lost data arm wrong");
  chk_arm_rx_full: assert property (ok |=> armed_conditions_out[2] == $past(ea[2]))
    else $error("rx full arm wrong");
  chk_arm_rx_data: assert property (ok |=> armed_conditions_out[3] == $past(ea[3]))
    else $error("rx data arm wrong");
  chk_arm_tx_space: assert property (ok |=> armed_conditions_out[4] == $past(ea[4]))
    else $error("tx space arm wrong");
  chk_arm_tx_empty: assert property (ok |=> armed_conditions_out[5] == $past(ea[5]))
    else $error("tx empty arm wrong");
  chk_arm_key: assert property (ok |=> armed_conditions_out[6] == $past(ea[6]))
    else $error("key arm wrong");
  chk_arm_autodisc: assert property (ok |=> armed_conditions_out[7] == $past(ea[7]))
    else $error("autodisconnect arm wrong");
  chk_arm_break: assert property (ok |=> armed_conditions_out[10:8] == {2'b00, $past(ea[8])})
    else $error("break arm wrong");
  chk_request_or: assert property (ok |=> service_request_out
                                   == ($past(request_enable_primary_out[3]) && (|$past(ea))))
    else $error("request combine wrong");
  chk_power_defaults: assert property ($fell(defaults_loading_out) |-> en == $past(dv))
    else $error("power-up defaults wrong");
  chk_key_defaults: assert property (reset_key_in |=> en == $past(dv) && !service_request_out)
    else $error("reset key defaults wrong");

  cover property ($rose(service_request_out));
  cover property ($fell(service_request_out));
  cover property (reset_key_in && request_switch_open_in);
endmodule
`default_nettype wire

//--- srq_loop_ctrl.sv
// Purpose: Loop controller model issuing decoded listener messages
// Assumes: Bench pushes messages into the queue
// Notes:   One message per cycle, back to back while queued
`timescale 1ns/1ns
`default_nettype none
module srq_loop_ctrl
  import srq_cond_pkg::*;
(
  input  wire logic              clk_sys_in,
  output srq_cond_pkg::loop_msg_t msg_out
);
  loop_msg_t q[$];
  initial msg_out = '0;
  always @(posedge clk_sys_in)
  begin
    #1;
    if (q.size() > 0)
      msg_out = q.pop_front();
    else
      msg_out = '{1'b0, msg_out.kind, ~msg_out.data};
  end
endmodule
`default_nettype wire

//--- service_request_condition_logic_tb.sv
// Purpose: Self-checking bench for the service-request condition block
// Assumes: Loop controller model feeds decoded messages
// Notes:   Expected values come from an integer register model
`timescale 1ns/1ns
`default_nettype none
module service_request_condition_logic_tb;
  import srq_cond_pkg::*;
  logic                  clk_sys_in, rst_b_in, key, sw, svc, ld;
  cond_t                 cnd;
  loop_msg_t             lm;
  reg_index_t            ci, hi;
  logic [COND_COUNT-1:0] arm;
  ctrl_val_t             ep, eb, ee, crd;
  char_val_t             hrd;
  int                    ctrl[14];
  int                    err_total, total_checks, i, j, v;

  srq_cond_top dut (.clk_sys_in, .rst_b_in, .reset_key_in(key), .request_switch_open_in(sw),
    .loop_msg_in(lm), .cond_in(cnd), .ctrl_rd_index_in(ci), .char_rd_index_in(hi),
    .service_request_out(svc), .armed_conditions_out(arm), .request_enable_primary_out(ep),
    .request_enable_buffers_out(eb), .request_enable_events_out(ee), .ctrl_rd_data_out(crd),
    .char_rd_data_out(hrd), .defaults_loading_out(ld));
  srq_loop_ctrl lc (.clk_sys_in, .msg_out(lm));

  initial
  begin
    clk_sys_in = 0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic msg(input msg_kind_t k, input int d);
    lc.q.push_back({1'b1, k, 8'(d)});
  endtask

  task automatic flush();
    int n;
    for (n = 0; n < 40 && lc.q.size() > 0; n++)
      tick(1);
    if (n == 40)
    begin
      err_total++;
      test_done();
    end
    tick(2);
  endtask

  task automatic dflt();
    foreach (ctrl[k])
      ctrl[k] = (k == 4) ? 15 : (k == 7) ? 14 : 0;
    ctrl[0] = sw ? 13 : 0;
    ctrl[1] = sw ? 5 : 0;
    ctrl[2] = sw ? 2 : 0;
  endtask

  function automatic logic [11:0] mdl();
    logic [10:0] a;
    a = '0;
    a[0] = ctrl[0][2] && (cnd.rx_parity_err || cnd.rx_frame_err || cnd.rx_overrun || cnd.rx_overflow);
    a[1] = ctrl[0][0] && cnd.rx_lost;
    a[2] = ctrl[1][3] && cnd.rx_full;
    a[3] = ctrl[1][2] && cnd.rx_not_empty;
    a[4] = ctrl[1][1] && cnd.tx_not_full;
    a[5] = ctrl[1][0] && cnd.tx_empty;
    a[6] = ctrl[2][2] && cnd.manual_request_key;
    a[7] = ctrl[2][1] && cnd.autodisconnect;
    a[8] = ctrl[2][0] && cnd.break_received;
    return {ctrl[0][3] && (a != 0), a};
  endfunction

  task automatic chk_all();
    cmp({ep, eb, ee}, {ctrl[0][3:0], ctrl[1][3:0], ctrl[2][3:0]});
    cmp({svc, arm}, mdl());
    cmp(ld, 0);
  endtask

  initial
  begin
    rst_b_in = 0;
    key = 0;
    sw = 0;
    cnd = '0;
    ci = '0;
    hi = '0;
    void'($urandom(67105));
    tick(8);
    rst_b_in = 1;
    tick(2);
    dflt();
    chk_all();
    sw = 1;
    cnd = '1;
    key = 1;
    tick(1);
    cmp(svc, 0);
    key = 0;
    tick(1);
    dflt();
    chk_all();
    $display("test defaults done");
    msg(MSG_DDL0, 0);
    msg(MSG_DATA, 12);
    msg(MSG_DATA, 5);
    msg(MSG_DATA, 2);
    msg(MSG_DDL0, 13);
    msg(MSG_DATA, 3);
    msg(MSG_DATA, 7);
    msg(MSG_REMOTE_WR, 8'he9);
    msg(MSG_DDL2, 11);
    msg(MSG_DATA, 8'ha5);
    msg(MSG_DATA, 8'h5a);
    flush();
    ctrl[0] = 12;
    ctrl[1] = 5;
    ctrl[2] = 2;
    ctrl[13] = 3;
    chk_all();
    for (i = 0; i < 15; i++)
    begin
      ci = i[3:0];
      tick(1);
      cmp(crd, (i < 14) ? ctrl[i % 14] : 0);
    end
    hi = 4'hb;
    tick(1);
    cmp(hrd, 8'ha5);
    hi = 4'hc;
    tick(1);
    cmp(hrd, 0);
    $display("test register access done");
    msg(MSG_CLR_EN, 3);
    msg(MSG_SET_EN, 8);
    msg(MSG_SET_EN, 8'h0c);
    flush();
    ctrl[0] = 4;
    ctrl[2] = 3;
    chk_all();
    ci = 4'h3;
    tick(1);
    cmp(crd, ctrl[3]);
    msg(MSG_SET_EN, 3);
    flush();
    ctrl[0] = 12;
    chk_all();
    $display("test bit set and clear done");
    for (i = 0; i < 40; i++)
    begin
      for (j = 0; j < 3; j++)
      begin
        v = $urandom_range(15);
        ctrl[j] = v;
        msg(MSG_REMOTE_WR, j * 16 + v);
      end
      flush();
      cnd = cond_t'(12'($urandom));
      tick(1);
      chk_all();
    end
    $display("test random conditions done");
    ci = 4'hd;
    hi = 4'hb;
    key = 1;
    tick(1);
    key = 0;
    tick(1);
    dflt();
    chk_all();
    cmp(crd, ctrl[13]);
    cmp(hrd, 8'h00);
    $display("test reset key reload done");
    msg(MSG_REMOTE_WR, 8'h40);
    flush();
    ci = 4'h4;
    sw = 0;
    rst_b_in = 0;
    tick(2);
    rst_b_in = 1;
    tick(2);
    dflt();
    chk_all();
    cmp(crd, ctrl[4]);
    $display("test second reset done");
    test_done();
  end
endmodule

bind srq_cond_top srq_cond_chk chk (.clk_sys_in, .rst_b_in, .reset_key_in, .request_switch_open_in, .cond_in,
  .service_request_out, .armed_conditions_out, .request_enable_primary_out, .request_enable_buffers_out,
  .request_enable_events_out, .defaults_loading_out);
`default_nettype wire
